// [common/eeprom_slave_consts.vh]
`ifndef EEPROM_SLAVE_CONSTS_VH
`define EEPROM_SLAVE_CONSTS_VH
// Select byte fields
`define DEV_TYPE 4'hA
`define CHIP_ENABLE 3'h0
// Address map
`define TAG_BASE 16'h1000
`define SCT_BASE 16'h1800
`define SYS_BASE 16'h1900
`define PWD_BASE 16'h1900
`define PWD_END 16'h1903
`define RPWD_BASE 16'h1904
`define RPWD_END 16'h1907
`define PINCFG_ADDR 16'h1908
`define LOCKB_BASE 16'h1910
`define LOCKB_END 16'h191F
`define UID_BASE 16'h1940
`define UID_END 16'h1948
`define SYS_END 16'h195F
// Reset values, field positions and sizes
`define PINCFG_RST 8'h00
`define PWD_RST 8'h00
`define ACT_MODE_BIT 7
`define PAGE_BYTES 7'h40
`define FIFO_DEPTH 2'h2
`endif

// [hdl/dual_port_eeprom_serial_slave.v]
// Contract
// - Mode bit 1: pull activity low for whole RF internal write.
// - Mode bit 1: activity released while serial writes execute.
// - Mode bit 0: pull low from RF frame start to command end.
// - Mode bit 0, bad RF command: low only until its CRC arrives.
// - Field loss releases the activity output at once.
// - Mode bit 0: activity released while any serial command executes.
// - Write select A0h, read A1h; data below 1000h; 1 to 64 bytes.
// - Unauthenticated 4-byte password write authenticates; mismatch gets no ack.
// - Locked data, tag or security area: no ack, no write cycle.
// - System area writes acked only when authenticated, else no cycle.
// - Identifier and internal areas: always no ack, nothing changes.
// - Unassigned area writes acked but store nothing.
// - Start is data falling with clock high; ignored during write cycle.
// - Stop is data rising with clock high; after read gives standby.
// - Receiver pulls data low in ninth clock to acknowledge.
// - Data sampled on rising clock; master changes it while clock low.
// - Select byte 1010b, chip enable 000b, then read bit; else standby.
// - Two address bytes then data, acked only when lock clear.
// - Write cycle starts only on stop right after an ack slot.
// - Page write: up to 63 more bytes, all written after stop.
// - Only low six address bits count, wrapping inside the page.
// - Select byte not acked during write cycle, acked afterwards.
// - Unauthenticated after reset; authenticated until reset or de-authentication.
// - Unauthenticated password read: no ack, ones; completed read de-authenticates.
// - Pin configuration bit 7 picks write-progress (1) or busy (0).
`include "eeprom_slave_consts.vh"
`default_nettype none
module dual_port_eeprom_serial_slave (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_scl,
  input wire i_sda,
  output wire o_sda,
  output wire o_sda_oe,
  input wire i_data_area_write_lock,
  input wire i_tag_area_write_lock,
  input wire i_security_area_write_lock,
  input wire i_rf_write_active,
  input wire i_rf_cmd_active,
  input wire i_rf_cmd_bad,
  input wire i_field_present,
  output wire o_rf_activity_output,
  output wire o_rf_activity_output_oe,
  output wire o_mem_wr_valid,
  output wire [15:0] o_mem_wr_addr,
  output wire [7:0] o_mem_wr_data,
  input wire i_mem_wr_ready,
  output wire [15:0] o_rd_addr,
  input wire [7:0] i_rd_data,
  output wire o_authenticated,
  output wire o_write_cycle_busy,
  output wire o_activity_mode
);
  localparam ST_IDLE = 2'd0;
  localparam ST_RX = 2'd1;
  localparam ST_TX = 2'd2;
  localparam ST_WCYC = 2'd3;
  localparam K_SEL = 2'd0;
  localparam K_AHI = 2'd1;
  localparam K_ALO = 2'd2;
  localparam K_DATA = 2'd3;
  localparam C_DATA = 3'd0;
  localparam C_TAG = 3'd1;
  localparam C_SCT = 3'd2;
  localparam C_SYS = 3'd3;
  localparam C_PWD = 3'd4;
  localparam C_RO = 3'd5;
  localparam C_NULL = 3'd6;

  function [2:0] area_class;
    input [15:0] a;
    begin
      if (a < `TAG_BASE)
        area_class = C_DATA;
      else if (a < `SCT_BASE)
        area_class = C_TAG;
      else if (a < `SYS_BASE)
        area_class = C_SCT;
      else if (a <= `PWD_END)
        area_class = C_PWD;
      else if (a <= `PINCFG_ADDR)
        area_class = C_SYS;
      else if (a >= `LOCKB_BASE && a <= `LOCKB_END)
        area_class = C_SYS;
      else if (a <= `SYS_END)
        area_class = C_RO;
      else
        area_class = C_NULL;
    end
  endfunction

  function in_pwd;
    input [15:0] a;
    begin
      in_pwd = ((a & 16'hFFFC) == `PWD_BASE);
    end
  endfunction

  reg scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
  reg [1:0] st_r, kind_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] sh_r;
  reg drive_r, rd_mode_r, wr_ok_r, store_r, auth_try_r, match_r, tx_nack_r;
  reg [6:0] nbytes_r, dr_idx_r;
  reg [15:0] addr_r;
  reg [5:0] start_lo_r;
  reg [7:0] pwd_r [0:3];
  reg [7:0] pin_cfg_r;
  reg auth_r, pwd_rd_r, act_r;
  reg [7:0] buf_r [0:63];
  reg [15:0] f_addr0_r, f_addr1_r;
  reg [7:0] f_data0_r, f_data1_r;
  reg [1:0] fcnt_r;
  integer i;

  wire scl_rise = scl_s_r & ~scl_d_r;
  wire scl_fall = ~scl_s_r & scl_d_r;
  wire start_cond = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  wire stop_cond = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
  wire [15:0] new_addr = {addr_r[15:8], sh_r};
  wire [2:0] new_cls = area_class(new_addr);
  wire [6:0] wr_count = (nbytes_r > `PAGE_BYTES) ? `PAGE_BYTES : nbytes_r;
  wire [5:0] dr_lo = start_lo_r + dr_idx_r[5:0];
  wire [15:0] dr_addr = {addr_r[15:6], dr_lo};
  wire push = (st_r == ST_WCYC) && (dr_idx_r < wr_count) && (fcnt_r != `FIFO_DEPTH);
  wire pop = (fcnt_r != 2'h0) && i_mem_wr_ready;
  wire buf_we = (st_r == ST_RX) && scl_fall && (bit_cnt_r == 4'h8) &&
    (kind_r == K_DATA) && wr_ok_r && !start_cond && !stop_cond;
  wire [7:0] rd_byte = pwd_rd_r ? pwd_r[addr_r[1:0]] : i_rd_data;
  wire mode_wip = pin_cfg_r[`ACT_MODE_BIT];
  reg lock_hit;
  reg ack_ok;

  // Ack decision for the low address byte
  always @*
  begin
    lock_hit = 1'b0;
    ack_ok = 1'b0;
    case (new_cls)
      C_DATA: lock_hit = i_data_area_write_lock;
      C_TAG: lock_hit = i_tag_area_write_lock;
      C_SCT: lock_hit = i_security_area_write_lock;
      default: lock_hit = 1'b0;
    endcase
    case (new_cls)
      C_DATA, C_TAG, C_SCT: ack_ok = ~lock_hit;
      C_SYS: ack_ok = auth_r;
      C_PWD: ack_ok = auth_r | (new_addr == `PWD_BASE);
      C_RO: ack_ok = 1'b0;
      default: ack_ok = 1'b1;
    endcase
  end

  // Two flops on the bus pins before any logic looks at them
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_m_r <= i_scl;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= i_sda;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  // Page buffer holds only the latest byte per page slot
  always @(posedge i_sys_clk)
  begin
    if (buf_we)
      buf_r[addr_r[5:0]] <= sh_r;
  end

  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_r <= ST_IDLE;
      kind_r <= K_SEL;
      bit_cnt_r <= 4'h0;
      sh_r <= 8'h00;
      drive_r <= 1'b0;
      rd_mode_r <= 1'b0;
      wr_ok_r <= 1'b0;
      store_r <= 1'b0;
      auth_try_r <= 1'b0;
      match_r <= 1'b0;
      tx_nack_r <= 1'b0;
      nbytes_r <= 7'h00;
      dr_idx_r <= 7'h00;
      addr_r <= 16'h0000;
      start_lo_r <= 6'h00;
      for (i = 0; i < 4; i = i + 1)
        pwd_r[i] <= `PWD_RST;
      pin_cfg_r <= `PINCFG_RST;
      auth_r <= 1'b0;
      pwd_rd_r <= 1'b0;
    end
    else
    begin
      case (st_r)
        ST_IDLE:
        begin
          drive_r <= 1'b0;
          if (start_cond)
          begin
            st_r <= ST_RX;
            kind_r <= K_SEL;
            bit_cnt_r <= 4'h0;
          end
        end
        ST_RX, ST_TX:
        begin
          if (stop_cond)
          begin
            drive_r <= 1'b0;
            st_r <= ST_IDLE;
            if (st_r == ST_TX && pwd_rd_r)
              auth_r <= 1'b0;
            pwd_rd_r <= 1'b0;
            // The stop's own clock rise has already counted one bit
            if (st_r == ST_RX && kind_r == K_DATA && bit_cnt_r == 4'h1 &&
                wr_ok_r && nbytes_r != 7'h00)
            begin
              if (auth_try_r)
              begin
                if (match_r && nbytes_r == 7'h04)
                  auth_r <= 1'b1;
              end
              else if (store_r)
              begin
                st_r <= ST_WCYC;
                dr_idx_r <= 7'h00;
              end
            end
          end
          else if (start_cond)
          begin
            drive_r <= 1'b0;
            st_r <= ST_RX;
            kind_r <= K_SEL;
            bit_cnt_r <= 4'h0;
            pwd_rd_r <= 1'b0;
          end
          else if (st_r == ST_RX && scl_rise)
          begin
            if (bit_cnt_r < 4'h8)
            begin
              sh_r <= {sh_r[6:0], sda_s_r};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
          else if (st_r == ST_RX && scl_fall && bit_cnt_r == 4'h8)
          begin
            bit_cnt_r <= 4'h9;
            case (kind_r)
              K_SEL:
              begin
                if (sh_r[7:4] != `DEV_TYPE || sh_r[3:1] != `CHIP_ENABLE)
                  st_r <= ST_IDLE;
                else if (sh_r[0] && in_pwd(addr_r) && !auth_r)
                  st_r <= ST_IDLE;
                else
                begin
                  drive_r <= 1'b1;
                  rd_mode_r <= sh_r[0];
                  pwd_rd_r <= sh_r[0] & in_pwd(addr_r);
                end
              end
              K_AHI:
              begin
                addr_r[15:8] <= sh_r;
                drive_r <= 1'b1;
              end
              K_ALO:
              begin
                addr_r[7:0] <= sh_r;
                start_lo_r <= sh_r[5:0];
                drive_r <= ack_ok;
                wr_ok_r <= ack_ok;
                auth_try_r <= (new_cls == C_PWD) && !auth_r;
                store_r <= (new_cls != C_NULL) && !((new_cls == C_PWD) && !auth_r);
                match_r <= 1'b1;
                nbytes_r <= 7'h00;
              end
              default:
              begin
                if (!wr_ok_r)
                  drive_r <= 1'b0;
                else
                begin
                  addr_r[5:0] <= addr_r[5:0] + 6'h01;
                  if (nbytes_r != 7'h7F)
                    nbytes_r <= nbytes_r + 7'h01;
                  if (auth_try_r)
                  begin
                    match_r <= match_r && nbytes_r < 7'h04 &&
                      sh_r == pwd_r[nbytes_r[1:0]];
                    drive_r <= match_r && nbytes_r < 7'h04 &&
                      sh_r == pwd_r[nbytes_r[1:0]];
                  end
                  else
                    drive_r <= 1'b1;
                end
              end
            endcase
          end
          else if (st_r == ST_RX && scl_fall && bit_cnt_r == 4'h9)
          begin
            bit_cnt_r <= 4'h0;
            drive_r <= 1'b0;
            if (kind_r == K_SEL && rd_mode_r)
            begin
              st_r <= ST_TX;
              sh_r <= rd_byte;
              drive_r <= ~rd_byte[7];
              tx_nack_r <= 1'b0;
            end
            else if (kind_r != K_DATA)
              kind_r <= kind_r + 2'd1;
          end
          else if (st_r == ST_TX && scl_rise)
          begin
            if (bit_cnt_r == 4'h8)
              tx_nack_r <= sda_s_r;
            if (bit_cnt_r < 4'h9)
              bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          else if (st_r == ST_TX && scl_fall)
          begin
            if (bit_cnt_r < 4'h8)
            begin
              sh_r <= {sh_r[6:0], 1'b1};
              drive_r <= ~sh_r[6];
            end
            else if (bit_cnt_r == 4'h8)
            begin
              drive_r <= 1'b0;
              addr_r <= addr_r + 16'h0001;
            end
            // Stay until the stop so a password read can close the session
            else if (tx_nack_r)
              drive_r <= 1'b0;
            else
            begin
              bit_cnt_r <= 4'h0;
              sh_r <= rd_byte;
              drive_r <= ~rd_byte[7];
            end
          end
        end
        default:
        begin
          // Bus ignored until every byte has left the buffer
          drive_r <= 1'b0;
          if (push)
          begin
            dr_idx_r <= dr_idx_r + 7'h01;
            if (dr_addr == `PINCFG_ADDR)
              pin_cfg_r <= buf_r[dr_lo];
            if (in_pwd(dr_addr))
              pwd_r[dr_addr[1:0]] <= buf_r[dr_lo];
          end
          else if (dr_idx_r >= wr_count && fcnt_r == 2'h0)
            st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Two-entry shift buffer toward the array; head always in entry 0
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      fcnt_r <= 2'h0;
      f_addr0_r <= 16'h0000;
      f_addr1_r <= 16'h0000;
      f_data0_r <= 8'h00;
      f_data1_r <= 8'h00;
    end
    else
    begin
      if (push && !pop)
      begin
        if (fcnt_r == 2'h0)
        begin
          f_addr0_r <= dr_addr;
          f_data0_r <= buf_r[dr_lo];
        end
        else
        begin
          f_addr1_r <= dr_addr;
          f_data1_r <= buf_r[dr_lo];
        end
        fcnt_r <= fcnt_r + 2'h1;
      end
      else if (pop && !push)
      begin
        f_addr0_r <= f_addr1_r;
        f_data0_r <= f_data1_r;
        fcnt_r <= fcnt_r - 2'h1;
      end
      else if (push && pop)
      begin
        if (fcnt_r == 2'h1)
        begin
          f_addr0_r <= dr_addr;
          f_data0_r <= buf_r[dr_lo];
        end
        else
        begin
          f_addr0_r <= f_addr1_r;
          f_data0_r <= f_data1_r;
          f_addr1_r <= dr_addr;
          f_data1_r <= buf_r[dr_lo];
        end
      end
    end
  end

  // Any serial activity releases the pin so the master never sees its own traffic
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      act_r <= 1'b0;
    else if (!i_field_present || st_r != ST_IDLE)
      act_r <= 1'b0;
    else if (mode_wip)
      act_r <= i_rf_write_active;
    else
      act_r <= i_rf_cmd_active & ~i_rf_cmd_bad;
  end

  assign o_rf_activity_output = 1'b0;
  assign o_rf_activity_output_oe = act_r;
  assign o_sda = 1'b0;
  assign o_sda_oe = drive_r;
  assign o_mem_wr_valid = (fcnt_r != 2'h0);
  assign o_mem_wr_addr = f_addr0_r;
  assign o_mem_wr_data = f_data0_r;
  assign o_rd_addr = addr_r;
  assign o_authenticated = auth_r;
  assign o_write_cycle_busy = (st_r == ST_WCYC);
  assign o_activity_mode = mode_wip;
endmodule
`default_nettype wire

// [tb/eeprom_slave_monitor.sv]
`include "eeprom_slave_consts.vh"
`default_nettype none
module eeprom_slave_monitor (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_oe,
  input wire logic i_data_area_write_lock,
  input wire logic i_tag_area_write_lock,
  input wire logic i_security_area_write_lock,
  input wire logic i_rf_cmd_active,
  input wire logic i_rf_cmd_bad,
  input wire logic i_field_present,
  input wire logic o_rf_activity_output_oe,
  input wire logic o_mem_wr_valid,
  input wire logic [15:0] o_mem_wr_addr,
  input wire logic i_mem_wr_ready,
  input wire logic o_authenticated,
  input wire logic o_write_cycle_busy,
  input wire logic o_activity_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  wire act = o_rf_activity_output_oe;
  wire v = o_mem_wr_valid;
  wire [15:0] a = o_mem_wr_addr;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  // Master leaves both lines high after a stop
  sequence s_idle; i_scl && i_sda; endsequence
  sequence s_quiet; !o_write_cycle_busy [*2]; endsequence
  property p_field; !i_field_present |=> !act; endproperty
  a_field: assert property (p_field) else $error("activity without field");
  property p_ser; o_write_cycle_busy |=> !act; endproperty
  a_ser: assert property (p_ser) else $error("activity in serial cycle");
  property p_busy; act && !o_activity_mode |-> $past(i_rf_cmd_active && !i_rf_cmd_bad); endproperty
  a_busy: assert property (p_busy) else $error("busy output uncaused");
  property p_cycle; $rose(o_write_cycle_busy) |-> s_idle; endproperty
  a_cycle: assert property (p_cycle) else $error("cycle without stop");
  property p_hold; v && !i_mem_wr_ready |=> v && $stable(a); endproperty
  a_hold: assert property (p_hold) else $error("entry lost in stall");
  property p_lock; v |-> !(i_data_area_write_lock && a < `TAG_BASE)
    && !(i_tag_area_write_lock && a >= `TAG_BASE && a < `SCT_BASE)
    && !(i_security_area_write_lock && a >= `SCT_BASE && a < `SYS_BASE); endproperty
  a_lock: assert property (p_lock) else $error("locked area written");
  property p_ro; v |-> a <= `LOCKB_END && !(a > `PINCFG_ADDR && a < `LOCKB_BASE); endproperty
  a_ro: assert property (p_ro) else $error("refused area written");
  property p_nack; o_write_cycle_busy |-> !o_sda_oe; endproperty
  a_nack: assert property (p_nack) else $error("answer during cycle");
  property p_sda; $changed(o_sda_oe) |-> !i_scl; endproperty
  a_sda: assert property (p_sda) else $error("data moved with clock high");
  property p_auth; $rose(o_authenticated) |-> s_idle ##1 s_quiet; endproperty
  a_auth: assert property (p_auth) else $error("bad authentication timing");
endmodule
bind dual_port_eeprom_serial_slave eeprom_slave_monitor u_mon (.i_sys_clk(i_sys_clk),
  .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda), .o_sda_oe(o_sda_oe),
  .i_data_area_write_lock(i_data_area_write_lock),
  .i_tag_area_write_lock(i_tag_area_write_lock),
  .i_security_area_write_lock(i_security_area_write_lock),
  .i_rf_cmd_active(i_rf_cmd_active), .i_rf_cmd_bad(i_rf_cmd_bad),
  .i_field_present(i_field_present), .o_rf_activity_output_oe(o_rf_activity_output_oe),
  .o_mem_wr_valid(o_mem_wr_valid), .o_mem_wr_addr(o_mem_wr_addr),
  .i_mem_wr_ready(i_mem_wr_ready), .o_authenticated(o_authenticated),
  .o_write_cycle_busy(o_write_cycle_busy), .o_activity_mode(o_activity_mode));
`default_nettype wire

// [tb/serial_master_model.sv]
`default_nettype none
module serial_master_model (
  input wire logic i_sys_clk,
  input wire logic i_sda,
  output var logic o_scl = 1'b1,
  output var logic o_pull = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  // Clock low five cycles, high three: one bit per 400 ns
  task automatic bit_x(input logic b, output logic r);
    o_scl <= 1'b0;
    cyc(1);
    o_pull <= ~b;
    cyc(4);
    o_scl <= 1'b1;
    cyc(1);
    r = i_sda;
    cyc(2);
  endtask
  // s low gives a start, s high a stop; clock then rests high
  task automatic cond(input logic s);
    o_scl <= 1'b0;
    cyc(1);
    o_pull <= s;
    cyc(4);
    o_scl <= 1'b1;
    cyc(3);
    o_pull <= ~s;
    cyc(6);
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(nak, r);
  endtask
endmodule
`default_nettype wire

// [tb/dual_port_eeprom_serial_slave_bench.sv]
`include "eeprom_slave_consts.vh"
`default_nettype none
module dual_port_eeprom_serial_slave_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_data_area_write_lock = 1'b0;
  logic i_tag_area_write_lock = 1'b0;
  logic i_security_area_write_lock = 1'b0;
  logic i_rf_write_active = 1'b0;
  logic i_rf_cmd_active = 1'b0;
  logic i_rf_cmd_bad = 1'b0;
  logic i_field_present = 1'b1;
  logic i_mem_wr_ready = 1'b0;
  logic [7:0] i_rd_data = 8'h00;
  logic rdy = 1'b0;
  logic tog = 1'b0;
  logic k;
  logic [1:0] ak;
  logic [7:0] d;
  logic [23:0] q[$];
  logic [15:0] la[3] = '{16'h0300, 16'h1200, 16'h1880};
  logic [15:0] ra[4] = '{`PINCFG_ADDR, `UID_BASE, 16'h1920, 16'h1960};
  int error_cnt = 0;
  int check_count = 0;
  wire i_scl, pull, o_sda, o_sda_oe, o_rf_activity_output, o_rf_activity_output_oe;
  wire o_mem_wr_valid, o_authenticated, o_write_cycle_busy, o_activity_mode;
  wire [15:0] o_mem_wr_addr, o_rd_addr;
  wire [7:0] o_mem_wr_data;
  // Pull-up on the shared data line
  wire i_sda = ~pull & (o_sda_oe ? o_sda : 1'b1);
  dual_port_eeprom_serial_slave DUT (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_scl(i_scl),
    .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
    .i_data_area_write_lock(i_data_area_write_lock),
    .i_tag_area_write_lock(i_tag_area_write_lock),
    .i_security_area_write_lock(i_security_area_write_lock),
    .i_rf_write_active(i_rf_write_active), .i_rf_cmd_active(i_rf_cmd_active),
    .i_rf_cmd_bad(i_rf_cmd_bad), .i_field_present(i_field_present),
    .o_rf_activity_output(o_rf_activity_output),
    .o_rf_activity_output_oe(o_rf_activity_output_oe), .o_mem_wr_valid(o_mem_wr_valid),
    .o_mem_wr_addr(o_mem_wr_addr), .o_mem_wr_data(o_mem_wr_data),
    .i_mem_wr_ready(i_mem_wr_ready), .o_rd_addr(o_rd_addr), .i_rd_data(i_rd_data),
    .o_authenticated(o_authenticated), .o_write_cycle_busy(o_write_cycle_busy),
    .o_activity_mode(o_activity_mode));
  serial_master_model m (.i_sys_clk(i_sys_clk), .i_sda(i_sda), .o_scl(i_scl), .o_pull(pull));
  initial forever #25 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk)
  begin
    // Stutter drops ready every other cycle so the buffer fills
    i_mem_wr_ready <= rdy & ~(tog & i_mem_wr_ready);
    i_rd_data <= o_rd_addr[7:0] ^ 8'h5A;
    if (o_mem_wr_valid && i_mem_wr_ready) q.push_back({o_mem_wr_addr, o_mem_wr_data});
  end
  task automatic chk(input string nm, input logic [23:0] s, input logic [23:0] e);
    check_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wsel(input logic [15:0] a, output logic [1:0] r);
    logic x;
    m.cond(1'b0);
    m.wr(8'hA0, x);
    r[1] = x;
    m.wr(a[15:8], x);
    m.wr(a[7:0], x);
    r[0] = x;
  endtask
  task automatic drain();
    for (int i = 0; i < 3000 && o_write_cycle_busy === 1'b1; i++) m.cyc(1);
    chk("drain", o_write_cycle_busy, 0);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #2000000;
    error_cnt++;
    stop_test();
  end
  initial
  begin
    m.cyc(20);
    i_rst <= 1'b0;
    m.cyc(4);
    chk("auth", o_authenticated, 0);
    chk("mode", o_activity_mode, 0);
    i_rf_cmd_active <= 1'b1;
    m.cyc(3);
    chk("busy", o_rf_activity_output_oe, 1);
    chk("actval", o_rf_activity_output, 0);
    i_rf_cmd_bad <= 1'b1;
    m.cyc(3);
    chk("bad", o_rf_activity_output_oe, 0);
    i_rf_cmd_bad <= 1'b0;
    m.cond(1'b0);
    m.wr(8'hA0, k);
    chk("ser", o_rf_activity_output_oe, 0);
    m.cond(1'b1);
    chk("back", o_rf_activity_output_oe, 1);
    i_field_present <= 1'b0;
    m.cyc(3);
    chk("field", o_rf_activity_output_oe, 0);
    i_rf_cmd_active <= 1'b0;
    i_field_present <= 1'b1;
    wsel(16'h0123, ak);
    chk("sel", ak, 2'b11);
    m.wr(8'h3C, k);
    chk("dat", k, 1);
    m.cond(1'b1);
    chk("cyc", o_write_cycle_busy, 1);
    // Receiver still stalled, so the cycle is surely running
    m.cond(1'b0);
    m.wr(8'hA0, k);
    chk("poll", k, 0);
    m.cond(1'b1);
    rdy <= 1'b1;
    drain();
    chk("n1", 24'(q.size()), 1);
    chk("ent", q.pop_front(), {16'h0123, 8'h3C});
    m.cond(1'b0);
    m.wr(8'hA1, k);
    chk("poll2", k, 1);
    m.rd(1'b1, d);
    m.cond(1'b1);
    chk("rd", d, 8'h24 ^ 8'h5A);
    wsel(16'h0200, ak);
    m.wr(8'h11, k);
    for (int i = 0; i < 4; i++) m.bit_x(1'b0, k);
    m.cond(1'b1);
    chk("mid", o_write_cycle_busy, 0);
    tog <= 1'b1;
    wsel(16'h0050, ak);
    for (int i = 0; i < 66; i++)
    begin
      m.wr(8'(i), k);
      chk("pg", k, 1);
    end
    m.cond(1'b1);
    drain();
    chk("n64", 24'(q.size()), 64);
    for (int i = 0; i < 64; i++) chk("pe", q[i], {10'h001, 6'(16 + i), 8'(i < 2 ? i + 64 : i)});
    q.delete();
    for (int j = 0; j < 3; j++)
    begin
      {i_security_area_write_lock, i_tag_area_write_lock, i_data_area_write_lock} <= 3'(1 << j);
      wsel(la[j], ak);
      m.wr(8'h55, k);
      m.cond(1'b1);
      chk("lock", {ak[0], k, o_write_cycle_busy}, 0);
    end
    {i_security_area_write_lock, i_tag_area_write_lock, i_data_area_write_lock} <= 3'h0;
    for (int j = 0; j < 4; j++)
    begin
      wsel(ra[j], ak);
      m.wr(8'h80, k);
      m.cond(1'b1);
      drain();
      chk("area", {ak[0], k}, j == 3 ? 2'b11 : 2'b00);
    end
    chk("nostore", 24'(q.size()), 0);
    wsel(`PWD_BASE, ak);
    m.wr(8'h01, k);
    chk("pbad", k, 0);
    m.cond(1'b1);
    wsel(`PWD_BASE, ak);
    for (int i = 0; i < 4; i++) m.wr(`PWD_RST, k);
    m.cond(1'b1);
    chk("pok", {k, o_authenticated}, 2'b11);
    wsel(`PINCFG_ADDR, ak);
    m.wr(8'h80, k);
    m.cond(1'b1);
    drain();
    chk("pin", {ak[0], k, o_activity_mode}, 3'b111);
    q.delete();
    i_rf_write_active <= 1'b1;
    m.cyc(3);
    chk("wip", o_rf_activity_output_oe, 1);
    rdy <= 1'b0;
    wsel(16'h0400, ak);
    m.wr(8'h66, k);
    m.cond(1'b1);
    chk("wipser", {o_write_cycle_busy, o_rf_activity_output_oe}, 2'b10);
    i_rf_write_active <= 1'b0;
    rdy <= 1'b1;
    drain();
    q.delete();
    wsel(`PWD_BASE, ak);
    m.cond(1'b0);
    m.wr(8'hA1, k);
    for (int i = 0; i < 4; i++) m.rd(i == 3, d);
    m.cond(1'b1);
    chk("prd", {k, d, o_authenticated}, {1'b1, `PWD_RST, 1'b0});
    wsel(`PWD_BASE, ak);
    m.cond(1'b0);
    m.wr(8'hA1, k);
    m.cond(1'b1);
    chk("pun", k, 0);
    stop_test();
  end
endmodule
`default_nettype wire
